// *** design/exec_pkg.sv ***
package exec_pkg;
  // Instruction opcode fields
  localparam logic [7:0] OPC_BRANCH_CARRY = 8'he2;
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam int OPC_BYTE_MSB = 15;
  localparam int OPC_NIB_MSB = 15;
  localparam int BIT_IDX_MSB = 11;
  localparam int BIT_IDX_LSB = 9;
  localparam int ACCESS_BIT_POS = 8;
  localparam int FILE_ADDR_MSB = 7;
  // Indexed literal offset window limit (95)
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  // Access bank split: low part is RAM, upper part is special registers
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [5:0] ACCESS_HIGH_BANK = 6'h3f;
  // Reset values
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [1:0] QPHASE_RESET = 2'h0;
  // Quarter phases
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} qphase_t;
  typedef enum {EXEC_RUN, EXEC_FLUSH} exec_state_t;
endpackage

// *** design/bank_address_gen.sv ***
`timescale 1ns/1ps
module bank_address_gen
  import exec_pkg::*;
(
  input wire logic [7:0] file_addr_i,
  input wire logic access_bit_i,
  input wire logic [5:0] bank_select_register_i,
  input wire logic ext_set_enable_i,
  input wire logic [13:0] index_base_i,
  output logic [13:0] data_addr_o,
  output logic indexed_o
);
  // Full 14-bit data address from the 8-bit field
  always_comb
  begin
    indexed_o = 1'b0;
    if (access_bit_i)
      data_addr_o = {bank_select_register_i, file_addr_i};
    else if (ext_set_enable_i && (file_addr_i <= INDEXED_LIMIT))
    begin
      // Offset is added to the index pointer, wraps within data space
      data_addr_o = index_base_i + {6'h00, file_addr_i};
      indexed_o = 1'b1;
    end
    else if (file_addr_i < ACCESS_SPLIT)
      data_addr_o = {6'h00, file_addr_i};
    else
      data_addr_o = {ACCESS_HIGH_BANK, file_addr_i};
  end
endmodule

// *** design/carry_branch_and_bit_clear_exec.sv ***
`timescale 1ns/1ps
module carry_branch_and_bit_clear_exec
  import exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] instr_i,
  input wire logic carry_i,
  input wire logic [5:0] bank_select_register_i,
  input wire logic ext_set_enable_i,
  input wire logic [13:0] index_base_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [1:0] qphase_o,
  output logic [20:0] pc_o,
  output logic pc_load_o,
  output logic flush_o,
  output logic [13:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic indexed_o
);
  // Instruction field decode; used for both opcode checks
  function automatic logic is_branch_carry(input logic [15:0] w);
    is_branch_carry = (w[OPC_BYTE_MSB -: 8] == OPC_BRANCH_CARRY);
  endfunction

  function automatic logic is_bit_clear(input logic [15:0] w);
    is_bit_clear = (w[OPC_NIB_MSB -: 4] == OPC_BIT_CLEAR);
  endfunction

  qphase_t q_reg, q_next;
  exec_state_t state_reg, state_next;
  logic [15:0] ir_reg, ir_next;
  logic [20:0] pc_reg, pc_next;
  logic [20:0] target_reg, target_next;
  logic [7:0] data_reg, data_next;
  logic [13:0] addr_reg, addr_next;
  logic idx_reg, idx_next;
  logic pc_load_reg, pc_load_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  logic flush_reg, flush_next;
  logic [13:0] addr_comb;
  logic idx_comb;
  logic [2:0] bit_sel;

  assign bit_sel = ir_reg[BIT_IDX_MSB:BIT_IDX_LSB];

  // Bank routing lives in its own module so other byte ops can share it
  // Fed from the raw word, so no loop closes through the next-state logic
  bank_address_gen u_bank (
    .file_addr_i(instr_i[FILE_ADDR_MSB:0]),
    .access_bit_i(instr_i[ACCESS_BIT_POS]),
    .bank_select_register_i(bank_select_register_i),
    .ext_set_enable_i(ext_set_enable_i),
    .index_base_i(index_base_i),
    .data_addr_o(addr_comb),
    .indexed_o(idx_comb)
  );

  // Quarter-phase counter; four edges make one instruction cycle
  always_comb
  begin
    case (q_reg)
      Q1: q_next = Q2;
      Q2: q_next = Q3;
      Q3: q_next = Q4;
      Q4: q_next = Q1;
      default: q_next = Q1; // Recover from a corrupted phase
    endcase
  end

  // Phase register; reset parks it in Q1 so the first fetch is 4 edges on
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q_reg <= qphase_t'(QPHASE_RESET);
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  // Flush flag kept in its own flop so the pin sees no decode after it
  always_comb
  begin
    flush_next = (state_next == EXEC_FLUSH);
  end

  // Flush register, cleared with the rest of the core
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      flush_reg <= 1'b0;
    end
    else
    begin
      flush_reg <= flush_next;
    end
  end

  // Quarter-cycle instruction execution
  always_comb
  begin
    state_next = state_reg;
    ir_next = ir_reg;
    pc_next = pc_reg;
    target_next = target_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    idx_next = idx_reg;
    pc_load_next = 1'b0;
    rd_next = 1'b0;
    wr_next = 1'b0;
    case (q_reg)
      Q4:
      begin
        // Latch next word at the boundary; a flush cycle discards it
        if (state_reg == EXEC_RUN)
        begin
          ir_next = instr_i;
          pc_next = pc_reg + 21'h000002; // Fetch advances PC
          if (is_bit_clear(instr_i))
          begin
            addr_next = addr_comb;
            idx_next = idx_comb;
          end
        end
        else
          ir_next = 16'h0000;
      end
      Q1:
      begin
        // Decode; the read strobe lands in Q2
        if (state_reg == EXEC_RUN && is_bit_clear(ir_reg))
          rd_next = 1'b1;
      end
      Q2:
      begin
        if (state_reg == EXEC_RUN && is_bit_clear(ir_reg))
          data_next = mem_rdata_i;
        if (state_reg == EXEC_RUN && is_branch_carry(ir_reg))
          target_next = pc_reg +
            {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
      end
      Q3:
      begin
        if (state_reg == EXEC_FLUSH)
          state_next = EXEC_RUN; // Idle cycle done
        else if (is_bit_clear(ir_reg))
        begin
          data_next[bit_sel] = 1'b0;
          wr_next = 1'b1;
        end
        else if (is_branch_carry(ir_reg) && carry_i)
        begin
          pc_next = target_reg;
          pc_load_next = 1'b1;
          state_next = EXEC_FLUSH;
        end
        // Carry clear: Q3 does nothing, PC stays sequential
      end
      default:
      begin
        pc_load_next = 1'b0;
      end
    endcase
  end

  // Register stage; status flags are never written here
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= EXEC_RUN;
      ir_reg <= 16'h0000;
      pc_reg <= PC_RESET;
      target_reg <= PC_RESET;
      data_reg <= 8'h00;
      addr_reg <= 14'h0000;
      idx_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ir_reg <= ir_next;
      pc_reg <= pc_next;
      target_reg <= target_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      idx_reg <= idx_next;
      pc_load_reg <= pc_load_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
    end
  end

  // Outputs straight from flip-flops
  assign qphase_o = q_reg;
  assign pc_o = pc_reg;
  assign pc_load_o = pc_load_reg;
  assign flush_o = flush_reg;
  assign mem_addr_o = addr_reg;
  assign mem_rd_o = rd_reg;
  assign mem_wr_o = wr_reg;
  assign mem_wdata_o = data_reg;
  assign indexed_o = idx_reg;
endmodule

// *** tb/exec_sva.sv ***
`timescale 1ns/1ps
module exec_sva (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [1:0] qphase_o,
  input wire logic [20:0] pc_o,
  input wire logic pc_load_o,
  input wire logic flush_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [7:0] mem_wdata_o
);
  // One clock domain, so clocking and reset are declared once
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Quarter schedule of the bit clear
  a_rd_then_wr: assert property (mem_rd_o |-> qphase_o == 2'h1 ##2 mem_wr_o)
    else $error("read not followed by write");
  a_rd_once: assert property (mem_rd_o |=> !mem_rd_o [*3])
    else $error("read strobe repeated");
  a_wr_in_q4: assert property (mem_wr_o |-> qphase_o == 2'h3 && !flush_o)
    else $error("write outside Q4");
  // At most one bit, whichever it is, may fall; the rest echo the Q2 read
  a_keep_bits: assert property (mem_wr_o |->
    !(mem_wdata_o & ~$past(mem_rdata_i, 2)) &&
    $countones($past(mem_rdata_i, 2) & ~mem_wdata_o) <= 1)
    else $error("write byte wrong");
  // Taken branch: load in Q4, then a whole idle cycle
  a_load_in_q4: assert property (pc_load_o |-> qphase_o == 2'h3 && flush_o)
    else $error("load outside Q4");
  a_flush_len: assert property (pc_load_o |=> flush_o [*3] ##1 !flush_o)
    else $error("flush length wrong");
  // PC only moves at the edges around Q4
  a_pc_steady: assert property (qphase_o < 2'h2 |=> $stable(pc_o))
    else $error("pc moved early");
  a_pc_seq: assert property (qphase_o == 2'h3 && !pc_load_o &&
    !$past(flush_o) |=> pc_o == $past(pc_o) + 21'h000002)
    else $error("pc not sequential");
endmodule
bind carry_branch_and_bit_clear_exec exec_sva exec_sva_i (.ref_clk_i,
  .resetn_i, .mem_rdata_i, .qphase_o, .pc_o, .pc_load_o, .flush_o,
  .mem_rd_o, .mem_wr_o, .mem_wdata_o);

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import exec_pkg::*;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic carry_i = 1'b0;
  logic [5:0] bank_select_register_i = 6'h00;
  logic ext_set_enable_i = 1'b0;
  logic [13:0] index_base_i = 14'h0000;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [1:0] qphase_o;
  logic [20:0] pc_o;
  logic [13:0] mem_addr_o;
  logic [7:0] mem_wdata_o;
  logic pc_load_o, flush_o, mem_rd_o, mem_wr_o, indexed_o;
  logic [31:0] s = 32'h0001748e;
  logic [7:0] n;
  int n_mismatch = 0;
  int check_count = 0;
  carry_branch_and_bit_clear_exec carry_branch_and_bit_clear_exec_i (
    .ref_clk_i, .resetn_i, .instr_i, .carry_i, .bank_select_register_i,
    .ext_set_enable_i, .index_base_i, .mem_rdata_i, .qphase_o, .pc_o,
    .pc_load_o, .flush_o, .mem_addr_o, .mem_rd_o, .mem_wr_o,
    .mem_wdata_o, .indexed_o);
  // Free-running clock, 8 ns period
  initial forever #4 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected indexed flag and data address
  function automatic logic [14:0] ea(input logic [7:0] f, input logic a,
    input logic [5:0] b, input logic e, input logic [13:0] ib);
    if (a) return {1'b0, b, f};
    if (e && f <= 8'h5f) return {1'b1, ib + {6'h00, f}};
    return {1'b0, f < 8'h60 ? 6'h00 : 6'h3f, f};
  endfunction
  task automatic check(input string nm, input logic [20:0] v, e);
    check_count++;
    if (v !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask
  // Offer a word in Q4 only, so a nop follows and nothing repeats
  task automatic issue(input logic [15:0] w);
    do @(negedge ref_clk_i); while (qphase_o !== 2'h2);
    @(posedge ref_clk_i);
    instr_i <= w;
    @(posedge ref_clk_i);
    instr_i <= 16'h0000;
  endtask
  task automatic branch(input logic c);
    logic [20:0] e;
    int ld = 0;
    @(posedge ref_clk_i);
    carry_i <= c;
    issue({OPC_BRANCH_CARRY, n});
    @(negedge ref_clk_i);
    e = c ? pc_o + {{12{n[7]}}, n, 1'b0} : pc_o;
    repeat (3)
    begin
      @(negedge ref_clk_i);
      ld += int'(pc_load_o === 1'b1);
    end
    check("pc_load", 21'(ld), 21'(c));
    check("pc", pc_o, e);
    // Skip past the idle cycle so no word lands in it
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic bclr(input logic [7:0] f, input logic a, e);
    logic [14:0] x;
    int k = 0;
    @(posedge ref_clk_i);
    bank_select_register_i <= s[31:26];
    ext_set_enable_i <= e;
    index_base_i <= s[13:0];
    mem_rdata_i <= s[7:0];
    issue({OPC_BIT_CLEAR, s[22:20], a, f});
    x = ea(f, a, s[31:26], e, s[13:0]);
    while (mem_wr_o !== 1'b1 && k < 8)
    begin
      @(negedge ref_clk_i);
      k++;
    end
    check("wr", 21'(mem_wr_o), 21'h1);
    check("addr", 21'(mem_addr_o), 21'(x[13:0]));
    check("indexed", 21'(indexed_o), 21'(x[14]));
    check("wdata", 21'(mem_wdata_o),
      21'(s[7:0] & ~(8'h01 << s[22:20])));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Corner offsets and addresses first, random mix after
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 30; i++)
    begin
      s = lfsr(s);
      n = i == 0 ? 8'h05 : i == 1 ? 8'h7f : i == 2 ? 8'h80 : s[15:8];
      if (i < 3 || (i > 5 && s[0]))
        branch(i < 3 || s[1]);
      else
        bclr(i == 3 ? 8'h5f : i == 4 ? 8'h60 : s[23:16], i > 5 && s[2],
          i < 6 || s[3]);
      $display("test %0d done", i);
    end
    conclude();
  end
  // Runs take about 300 cycles; this bound means a hang
  initial
  begin
    repeat (3000) @(posedge ref_clk_i);
    n_mismatch++;
    conclude();
  end
endmodule
